/* fan_ovr_pkg.sv */
package fan_ovr_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_USER_LOCAL = 8'h13;
	localparam logic [7:0] ADDR_USER_REMOTE = 8'h14;
	localparam logic [7:0] ADDR_FIXED_LOCAL = 8'h17;
	localparam logic [7:0] ADDR_FIXED_REMOTE = 8'h18;
	localparam logic [7:0] ADDR_FAN_DAC = 8'h19;
	localparam logic [7:0] ADDR_CHAN_MODE = 8'h49;
	localparam logic [7:0] ADDR_CONFIG2 = 8'h4A;
	localparam logic [7:0] ADDR_STATUS = 8'h4B;
	// Reset values, full-scale code and zero read data
	localparam logic [7:0] DAC_RESET = 8'hFF;
	localparam logic [7:0] DAC_FULL = 8'hFF;
	localparam logic [7:0] LOCAL_LIMIT_RESET = 8'h46;
	localparam logic [7:0] REMOTE_LIMIT_RESET = 8'h55;
	localparam logic [1:0] CHAN_MODE_RESET = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Field positions in the second configuration register
	localparam int LOCK_LOCAL_BIT = 1;
	localparam int LOCK_REMOTE_BIT = 2;
	// Status register fields
	localparam int STAT_OVR_BIT = 0;
	localparam int STAT_PIN_BIT = 1;
	// Override behaviour
	localparam int TRIP_COUNT = 3;
	localparam int CNT_W = 2;
	localparam logic signed [8:0] HYST_DEG = 9'sh005;
	// Sensor identifiers on the measurement port
	localparam logic [1:0] SENS_LOCAL = 2'h0;
	localparam logic [1:0] SENS_REMOTE1 = 2'h1;
	localparam logic [1:0] SENS_REMOTE2 = 2'h2;
	// Number of limit/sensor pairs watched
	localparam int NUM_COND = 6;
endpackage

/* limit_watch.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches one limit against one sensor and keeps the trip state
module limit_watch
	import fan_ovr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Measurement of this sensor
	input wire logic meas_hit,
	input wire logic [7:0] meas_temp,
	input wire logic [7:0] limit,
	// Trip state
	output logic tripped_q
);
	logic [CNT_W-1:0] over_cnt_q; // Consecutive over-limit results
	logic [CNT_W-1:0] rel_cnt_q; // Consecutive results below the release point
	logic over; // Result above limit
	logic rel; // Result at least the hysteresis below limit
	localparam logic [CNT_W-1:0] LAST = CNT_W'(TRIP_COUNT - 1);

	// Signed compare; widened so limit minus hysteresis cannot wrap
	always_comb begin
		over = $signed(meas_temp) > $signed(limit);
		rel = $signed({meas_temp[7], meas_temp}) <= ($signed({limit[7], limit}) - HYST_DEG);
	end

	// Counters clear on any result that breaks the run
	always_ff @(posedge core_clk) begin
		if (rst) begin
			over_cnt_q <= '0;
			rel_cnt_q <= '0;
		end else if (meas_hit) begin
			over_cnt_q <= over ? ((over_cnt_q == LAST) ? LAST : over_cnt_q + 1'b1) : '0;
			rel_cnt_q <= rel ? ((rel_cnt_q == LAST) ? LAST : rel_cnt_q + 1'b1) : '0;
		end
	end

	// Trip on the third over result, release on the third cool result
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tripped_q <= 1'b0;
		end else if (meas_hit && !tripped_q && over && over_cnt_q == LAST) begin
			tripped_q <= 1'b1;
		end else if (meas_hit && tripped_q && rel && rel_cnt_q == LAST) begin
			tripped_q <= 1'b0;
		end
	end

	// Trip only ever follows an over-limit result
	trip_cause_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(tripped_q) |-> $past(meas_hit) && $past(over) && $past(over_cnt_q) == LAST)
		else $error("trip without three over results");
endmodule
`default_nettype wire

/* fan_dac_thermal_override.sv */
// Function
// - Hold an eight-bit unsigned fan output code
// - Output code resets to all ones
// - Three consecutive over-limit results force full scale
// - Local result above user local limit trips
// - Either remote above user remote limit trips
// - Local above fixed 70 degree limit trips
// - Either remote above fixed 85 degree trips
// - Release after three results five degrees below
// - Low overtemp pin forces full scale output
// - User limits reset to the fixed values
// - Writing ones to config bits 1,2 locks
// - Lock bits set only, cleared by resets
// - Locked user limits ignore writes
// - Channel mode bits pick tacho or analog
// - Channel mode bits reset to tacho inputs
// - Temperatures are signed two's complement degrees
`timescale 1ns/1ps
`default_nettype none
module fan_dac_thermal_override
	import fan_ovr_pkg::*;
(
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic rst,
	// Reset pin, active low, synchronous
	input wire logic reset_pin_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Temperature results from the measurement engine
	input wire logic meas_valid,
	input wire logic [1:0] meas_sensor,
	input wire logic [7:0] meas_temp,
	// Overtemperature force pin, active low
	input wire logic overtemp_force_input_n,
	// Converter code and pin mode
	output logic [7:0] dac_out,
	output logic [1:0] chan_mode
);
	// Software-written converter code
	logic [7:0] dac_code_q;
	// User limits
	logic [7:0] user_local_q;
	logic [7:0] user_remote_q;
	// Lock bits: [0] local, [1] remote
	logic [1:0] lock_q;
	// Channel mode bits
	logic [1:0] chan_mode_q;
	// Registered outputs
	logic [7:0] dac_out_q;
	logic [7:0] rdata_q;
	// Override state
	logic [NUM_COND-1:0] trip;
	logic override;
	logic pin_force;
	// Write decode
	logic wr_local;
	logic wr_remote;

	// Fixed limits are wired constants, never writable
	// Software can read them back, but no write address reaches them
	localparam logic [7:0] FIXED_LOCAL = LOCAL_LIMIT_RESET;
	localparam logic [7:0] FIXED_REMOTE = REMOTE_LIMIT_RESET;

	// Per-condition sensor and limit choice
	// Entry n feeds watcher n; user pairs first, fixed pairs after
	logic [1:0] cond_sensor [NUM_COND];
	logic [7:0] cond_limit [NUM_COND];

	always_comb begin
		// Local against user limit
		cond_sensor[0] = SENS_LOCAL;
		cond_limit[0] = user_local_q;
		// Each remote against user remote limit
		cond_sensor[1] = SENS_REMOTE1;
		cond_limit[1] = user_remote_q;
		cond_sensor[2] = SENS_REMOTE2;
		cond_limit[2] = user_remote_q;
		// Local against fixed limit
		cond_sensor[3] = SENS_LOCAL;
		cond_limit[3] = FIXED_LOCAL;
		// Each remote against fixed limit
		cond_sensor[4] = SENS_REMOTE1;
		cond_limit[4] = FIXED_REMOTE;
		cond_sensor[5] = SENS_REMOTE2;
		cond_limit[5] = FIXED_REMOTE;
	end

	// One watcher per limit and sensor pair
	// A shared counter per sensor would let one limit's release hide another's trip
	genvar gi;
	generate
		for (gi = 0; gi < NUM_COND; gi++) begin : g_cond
			limit_watch u_watch (
				.core_clk(core_clk),
				.rst(rst),
				.meas_hit(meas_valid && meas_sensor == cond_sensor[gi]),
				.meas_temp(meas_temp),
				.limit(cond_limit[gi]),
				.tripped_q(trip[gi])
			);
		end
	endgenerate

	// Any tripped watcher forces full scale
	// The pin is not resynchronised; it must already be synchronous to core_clk
	always_comb begin
		override = |trip;
		pin_force = !overtemp_force_input_n;
	end

	// Limit writes are dropped while locked
	// Decoding the lock here keeps the limit processes free of lock detail
	always_comb begin
		wr_local = reg_wr && reg_addr == ADDR_USER_LOCAL && !lock_q[0];
		wr_remote = reg_wr && reg_addr == ADDR_USER_REMOTE && !lock_q[1];
	end

	// User local limit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			user_local_q <= LOCAL_LIMIT_RESET;
		end else if (wr_local) begin
			user_local_q <= reg_wdata;
		end
	end

	// User remote limit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			user_remote_q <= REMOTE_LIMIT_RESET;
		end else if (wr_remote) begin
			user_remote_q <= reg_wdata;
		end
	end

	// Lock bits: only ones stick; zeros written are ignored
	// The reset pin reaches only the locks; the limits keep their values
	always_ff @(posedge core_clk) begin
		if (rst || !reset_pin_n) begin
			lock_q <= '0;
		end else if (reg_wr && reg_addr == ADDR_CONFIG2) begin
			lock_q[0] <= lock_q[0] | reg_wdata[LOCK_LOCAL_BIT];
			lock_q[1] <= lock_q[1] | reg_wdata[LOCK_REMOTE_BIT];
		end
	end

	// Channel mode bits
	// Only the bits live here; the pin switching itself is in the analog front end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_mode_q <= CHAN_MODE_RESET;
		end else if (reg_wr && reg_addr == ADDR_CHAN_MODE) begin
			chan_mode_q <= reg_wdata[1:0];
		end
	end

	// Software converter code; left alone by the override
	// Software reads back its own value even while the output is forced
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dac_code_q <= DAC_RESET;
		end else if (reg_wr && reg_addr == ADDR_FAN_DAC) begin
			dac_code_q <= reg_wdata;
		end
	end

	// Converter output; one flop so the pin sees no decode glitch
	// Trade-off: a force or a release reaches the pin one cycle late
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dac_out_q <= DAC_RESET;
		end else if (override || pin_force) begin
			dac_out_q <= DAC_FULL;
		end else begin
			dac_out_q <= dac_code_q;
		end
	end

	// Read data, valid the cycle after the read strobe
	// Status is live, not latched, so software may miss a short pin pulse
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= READ_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_USER_LOCAL: rdata_q <= user_local_q;
				ADDR_USER_REMOTE: rdata_q <= user_remote_q;
				ADDR_FIXED_LOCAL: rdata_q <= FIXED_LOCAL;
				ADDR_FIXED_REMOTE: rdata_q <= FIXED_REMOTE;
				ADDR_FAN_DAC: rdata_q <= dac_code_q;
				ADDR_CHAN_MODE: rdata_q <= {6'h00, chan_mode_q};
				ADDR_CONFIG2: begin
					// Only the lock bits exist here
					rdata_q <= READ_ZERO;
					rdata_q[LOCK_LOCAL_BIT] <= lock_q[0];
					rdata_q[LOCK_REMOTE_BIT] <= lock_q[1];
				end
				ADDR_STATUS: begin
					// Live override state for software
					rdata_q <= READ_ZERO;
					rdata_q[STAT_OVR_BIT] <= override;
					rdata_q[STAT_PIN_BIT] <= pin_force;
				end
				default: rdata_q <= READ_ZERO;
			endcase
		end else begin
			// Data stand one cycle only
			rdata_q <= READ_ZERO;
		end
	end

	// Outputs
	// Read data, output code and mode all come straight from flops
	always_comb begin
		reg_rdata = rdata_q;
		dac_out = dac_out_q;
		chan_mode = chan_mode_q;
	end

	// Pin low forces full scale next cycle
	pin_force_a: assert property (@(posedge core_clk) disable iff (rst)
		!overtemp_force_input_n |=> dac_out == 8'hFF)
		else $error("pin did not force full scale");

	// Watcher trip forces full scale next cycle
	trip_force_a: assert property (@(posedge core_clk) disable iff (rst)
		override |=> dac_out == 8'hFF)
		else $error("override did not force full scale");

	// Without any force, the software code is driven
	code_restore_a: assert property (@(posedge core_clk) disable iff (rst)
		!override && overtemp_force_input_n |=> dac_out == $past(dac_code_q))
		else $error("software code not restored");

	// Power-on values of code and limits
	reset_vals_a: assert property (@(posedge core_clk)
		!rst && $past(rst) |-> dac_code_q == DAC_RESET && user_local_q == LOCAL_LIMIT_RESET
		&& user_remote_q == REMOTE_LIMIT_RESET)
		else $error("wrong reset values");

	// Channel mode starts as tacho inputs
	mode_reset_a: assert property (@(posedge core_clk)
		!rst && $past(rst) |-> chan_mode == CHAN_MODE_RESET)
		else $error("channel mode not cleared");

	// Locked limit holds across a write
	lock_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		lock_q[0] && reg_wr && reg_addr == ADDR_USER_LOCAL |=> $stable(user_local_q))
		else $error("locked limit changed");

	// Lock stays set until a reset
	lock_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
		lock_q[1] && reset_pin_n |=> lock_q[1])
		else $error("lock bit cleared by write");

	// Writing a one sets the lock
	lock_set_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_CONFIG2 && reg_wdata[1] && reset_pin_n |=> lock_q[0])
		else $error("lock bit not set");

	// Reset pin clears both locks
	lock_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		!reset_pin_n |=> lock_q == 2'h0)
		else $error("reset pin left lock set");

	// Read data return one cycle after the strobe only
	read_gap_a: assert property (@(posedge core_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");

	// Power-on reset drives full scale on the next cycle
	dac_reset_a: assert property (@(posedge core_clk)
		rst |=> dac_out == DAC_RESET)
		else $error("output not full scale after reset");

	// Power-on reset loads the user limits with the fixed values
	limit_reset_a: assert property (@(posedge core_clk)
		rst |=> user_local_q == LOCAL_LIMIT_RESET && user_remote_q == REMOTE_LIMIT_RESET)
		else $error("user limits not at reset values");

	// Fixed local limit reads back unchanged
	fixed_local_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_FIXED_LOCAL |=> reg_rdata == FIXED_LOCAL)
		else $error("fixed local limit wrong");

	// Fixed remote limit reads back unchanged
	fixed_remote_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_FIXED_REMOTE |=> reg_rdata == FIXED_REMOTE)
		else $error("fixed remote limit wrong");

	// Mode write reaches the mode pins
	mode_write_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_CHAN_MODE |=> chan_mode == $past(reg_wdata[1:0]))
		else $error("mode write lost");

	// Code write is stored as written
	code_write_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_FAN_DAC |=> dac_code_q == $past(reg_wdata))
		else $error("code write lost");

	// Code reads back the software value, forced or not
	code_read_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_FAN_DAC |=> reg_rdata == $past(dac_code_q))
		else $error("code read wrong");

	// Writing a one sets the remote lock
	remote_lock_set_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == ADDR_CONFIG2 && reg_wdata[LOCK_REMOTE_BIT] && reset_pin_n |=> lock_q[1])
		else $error("remote lock not set");

	// Local lock stays set until a reset
	local_lock_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		lock_q[0] && reset_pin_n |=> lock_q[0])
		else $error("local lock cleared by write");

	// Locked remote limit holds across a write
	remote_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		lock_q[1] && reg_wr && reg_addr == ADDR_USER_REMOTE |=> $stable(user_remote_q))
		else $error("locked remote limit changed");

	// Unlocked local limit takes the written value
	user_write_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_local |=> user_local_q == $past(reg_wdata))
		else $error("unlocked limit write lost");

	// Lock bits read back at their field positions
	lock_read_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_CONFIG2 |=> reg_rdata[LOCK_LOCAL_BIT] == $past(lock_q[0])
		&& reg_rdata[LOCK_REMOTE_BIT] == $past(lock_q[1]))
		else $error("lock read wrong");

	// Status shows the live override and pin state
	status_read_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[STAT_OVR_BIT] == $past(override)
		&& reg_rdata[STAT_PIN_BIT] == $past(pin_force))
		else $error("status read wrong");

	// Mode bits read back as stored
	mode_read_a: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == ADDR_CHAN_MODE |=> reg_rdata[1:0] == $past(chan_mode_q))
		else $error("mode read wrong");
endmodule
`default_nettype wire

/* fan_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Amplifier and transistor stage behind the converter
module fan_drive_model (
	// Converter code in
	input wire logic [7:0] dac_code,
	// Fan supply in millivolts
	output logic [15:0] fan_mv
);
	// Linear gain of about 4.8; full code reaches the 12 V rail, zero stops the fan
	assign fan_mv = 16'((32'(dac_code) * 12000) / 255);
endmodule
`default_nettype wire

/* fan_dac_thermal_override_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module fan_dac_thermal_override_test;
	import fan_ovr_pkg::*;
	// Design stimulus, all given a value at time zero
	logic core_clk = 0, rst = 1, reset_pin_n = 1, reg_wr = 0, reg_rd = 0, meas_valid = 0;
	logic overtemp_force_input_n = 1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, meas_temp = 8'h00;
	logic [1:0] meas_sensor = 2'h0;
	// Design and partner outputs
	logic [7:0] reg_rdata, dac_out;
	logic [1:0] chan_mode;
	logic [15:0] fan_mv;
	// Model state: limits, code, mode, locks, run counters, trip flags
	int ul = 'h46, ur = 'h55, code = 'hFF, cm = 0, lk = 0;
	int cnt[6];
	int psens[6] = '{0, 1, 2, 0, 1, 2};
	logic [5:0] trip = 6'h00;
	int n_errors = 0, samples_checked = 0, cycles = 0;
	logic [31:0] seed = 70188;

	fan_dac_thermal_override dut_u (.core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas_sensor(meas_sensor),
		.meas_temp(meas_temp), .overtemp_force_input_n(overtemp_force_input_n),
		.dac_out(dac_out), .chan_mode(chan_mode));
	fan_drive_model fan_u (.dac_code(dac_out), .fan_mv(fan_mv));

	// Free-running 100 MHz clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard; the whole run needs well under this
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// Pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Closing report
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// One-cycle register write, mirrored into the model
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		case (a)
			ADDR_USER_LOCAL: if (lk[1] == 0) ul = d;
			ADDR_USER_REMOTE: if (lk[2] == 0) ur = d;
			ADDR_FAN_DAC: code = d;
			ADDR_CHAN_MODE: cm = d[1:0];
			ADDR_CONFIG2: lk = lk | (d & 6);
			default: ;
		endcase
	endtask

	// One-cycle read; data stands only in the following cycle
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask

	// One result plus pin level; model runs each pair of that sensor, then dac is compared
	task automatic meas(input logic [1:0] s, input logic [7:0] t, input logic pin);
		int lim;
		@(posedge core_clk);
		meas_valid <= 1'b1;
		meas_sensor <= s;
		meas_temp <= t;
		overtemp_force_input_n <= pin;
		@(posedge core_clk);
		meas_valid <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (psens[i] != s) continue;
			lim = (i < 3) ? $signed(i == 0 ? ul[7:0] : ur[7:0]) : (i == 3 ? 70 : 85);
			if (trip[i] ? ($signed(t) <= lim - 5) : ($signed(t) > lim)) cnt[i]++;
			else cnt[i] = 0;
			if (cnt[i] == 3) begin
				trip[i] = !trip[i];
				cnt[i] = 0;
			end
		end
		@(posedge core_clk);
		#1 `CHK(dac_out, ((|trip) || !pin) ? 8'hFF : 8'(code))
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		chk_rd(ADDR_USER_LOCAL, 8'd70);
		chk_rd(ADDR_USER_REMOTE, 8'd85);
		chk_rd(ADDR_FIXED_LOCAL, 8'd70);
		chk_rd(ADDR_FIXED_REMOTE, 8'd85);
		chk_rd(ADDR_FAN_DAC, 8'hFF);
		chk_rd(ADDR_CHAN_MODE, 8'h00);
		chk_rd(ADDR_CONFIG2, 8'h00);
		chk_rd(ADDR_STATUS, 8'h00);
		chk_rd(8'h30, 8'h00);
		`CHK(chan_mode, 2'h0)
		`CHK(fan_mv, 16'd12000)
		// Every pin mode, read back and seen at the port
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CHAN_MODE, 8'(m));
			chk_rd(ADDR_CHAN_MODE, 8'(cm));
			`CHK(chan_mode, 2'(cm))
		end
		// Fixed limit ignores writes
		wr(ADDR_FIXED_LOCAL, 8'h00);
		chk_rd(ADDR_FIXED_LOCAL, 8'd70);
		// Limits kept below the fixed ones; lock one, then the other
		wr(ADDR_USER_LOCAL, 8'd60);
		wr(ADDR_CONFIG2, 8'h02);
		wr(ADDR_USER_LOCAL, 8'd20);
		wr(ADDR_USER_REMOTE, 8'd75);
		wr(ADDR_CONFIG2, 8'h00);
		wr(ADDR_CONFIG2, 8'h04);
		wr(ADDR_USER_REMOTE, 8'd20);
		chk_rd(ADDR_USER_LOCAL, 8'(ul));
		chk_rd(ADDR_USER_REMOTE, 8'(ur));
		chk_rd(ADDR_CONFIG2, 8'(lk));
		// Reset pin frees the locks but keeps the limits
		@(posedge core_clk);
		reset_pin_n <= 1'b0;
		@(posedge core_clk);
		reset_pin_n <= 1'b1;
		lk = 0;
		chk_rd(ADDR_CONFIG2, 8'(lk));
		chk_rd(ADDR_USER_LOCAL, 8'(ul));
		wr(ADDR_USER_LOCAL, 8'd65);
		chk_rd(ADDR_USER_LOCAL, 8'(ul));
		seed = lfsr(seed);
		wr(ADDR_FAN_DAC, seed[7:0]);
		// Large negative reading must not look hot
		repeat (3) meas(SENS_LOCAL, 8'h9C, 1'b1);
		// Random results around the limits, sensor 3 included, pin pulled low now and then
		for (int k = 0; k < 600; k++) begin
			seed = lfsr(seed);
			if (k % 50 == 25) wr(ADDR_FAN_DAC, seed[31:24]);
			meas(seed[1:0], 8'(int'(seed[15:8]) % 70 + 30), seed[20:18] != 3'h0);
			if (k % 8 == 0) chk_rd(ADDR_STATUS, 8'({!overtemp_force_input_n, |trip}));
		end
		chk_rd(ADDR_FAN_DAC, 8'(code));
		print_verdict();
	end
endmodule
`default_nettype wire
